// ===== verilog/bmb_ctrl.sv
// Control logic of a one-channel brushed motor H-bridge.
// Assumes async direction inputs and comparator levels; one clock.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// (RULE1) A-only: A high B low; B-only reverse; both high: brake low.
// (RULE2) Both inputs low: all switches off, outputs float; standby later.
// (RULE3) Standby after both inputs low for the standby delay, about 1 ms.
// (RULE4) Host keeps inputs stable during the standby transition window.
// (RULE5) Host keeps both-low at or under 0.7 ms to stay in stop.
// (RULE6) Host holds both-low at least 1.5 ms to reach standby.
// (RULE7) Either input high wakes from standby; outputs follow within 30 us.
// (RULE8) Sense comparator ignored for 3.6 us on each decay-to-charge.
// (RULE9) Threshold comparison also blanked 400 ns near the threshold.
// (RULE10) Every direction input change restarts the charge blanking.
// (RULE11) After threshold: fixed off time, half fast decay, half slow.
// (RULE12) Zero current in fast decay turns all switches off.
// (RULE13) Charge, fast and slow decay switch patterns, mirrored in reverse.
// (RULE14) Dead time of 200 to 300 ns at every leg switching.
// (RULE15) Charge ends once sensed current hits reference/10 over resistance.
// (RULE16) Host keeps input switching rate at or below 400 kHz.
// (RULE17) Overcurrent after mask time: switches off, auto recovery later.
// (RULE18) Thermal or undervoltage trip holds switches off until cleared.
// (RULE19) Charge drives selected direction; recharge after each off time.
// (RULE20) Standby keeps all four switches off until an input goes high.
module bmb_ctrl #(
  parameter int STANDBY_CYC = bmb_pkg::STANDBY_CYC,
  parameter int OC_RECOVER_CYC = bmb_pkg::OC_RECOVER_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic direction_input_a,
  input wire logic direction_input_b,
  input wire logic current_threshold_level,
  input wire logic zero_current,
  input wire logic overcurrent_trip,
  input wire logic thermal_trip,
  input wire logic undervoltage_trip,
  output logic high_side_a,
  output logic high_side_b,
  output logic low_side_a,
  output logic low_side_b,
  output logic standby
);
  typedef enum logic [2:0] {
    BMB_STANDBY, BMB_WAKE, BMB_RUN, BMB_FAST, BMB_SLOW, BMB_FLOAT
  } bmb_phase_t;

  typedef struct packed {
    logic [2:0] sa;
    logic [2:0] sb;
    logic [2:0] sthr;
    logic [2:0] szero;
    logic [2:0] soc;
    logic [2:0] sfault;
    bmb_phase_t phase;
    logic [bmb_pkg::CNT_W-1:0] idle;
    logic [bmb_pkg::CNT_W-1:0] tmr;
    logic [bmb_pkg::CNT_W-1:0] blank;
    logic [bmb_pkg::CNT_W-1:0] thr_run;
    logic [bmb_pkg::CNT_W-1:0] oc_run;
    logic [bmb_pkg::CNT_W-1:0] oc_hold;
    logic a;
    logic b;
    logic rev;
    logic wa_h;
    logic wa_l;
    logic wb_h;
    logic wb_l;
  } bmb_ctrl_t;

  bmb_ctrl_t st;
  bmb_ctrl_t next_st;
  logic a_now;
  logic b_now;
  logic thr_now;
  logic zero_now;
  logic oc_now;
  logic fault_now;

  // Filtered levels: valid once second and third stages agree
  assign a_now = (st.sa[1] == st.sa[2]) ? st.sa[2] : st.a;
  assign b_now = (st.sb[1] == st.sb[2]) ? st.sb[2] : st.b;
  assign thr_now = st.sthr[1] && st.sthr[2];
  assign zero_now = st.szero[1] && st.szero[2];
  assign oc_now = st.soc[1] && st.soc[2];
  assign fault_now = st.sfault[1] && st.sfault[2];

  always_comb begin
    next_st = st;
    next_st.sa = {st.sa[1:0], direction_input_a};
    next_st.sb = {st.sb[1:0], direction_input_b};
    next_st.sthr = {st.sthr[1:0], current_threshold_level};
    next_st.szero = {st.szero[1:0], zero_current};
    next_st.soc = {st.soc[1:0], overcurrent_trip};
    next_st.sfault = {st.sfault[1:0], thermal_trip || undervoltage_trip};
    next_st.a = a_now;
    next_st.b = b_now;
    if (st.tmr != '0) begin
      next_st.tmr = st.tmr - 1'b1;
    end
    if (st.blank != '0) begin
      next_st.blank = st.blank - 1'b1;
    end
    // Input edges restart charge blanking, helps direct PWM
    if (a_now != st.a || b_now != st.b) begin
      next_st.blank = bmb_pkg::CNT_W'(bmb_pkg::CHARGE_BLANK_CYC); // RULE10
    end
    // Threshold must persist through its own blanking window
    if (thr_now) begin
      if (st.thr_run != bmb_pkg::CNT_W'(bmb_pkg::THRESH_BLANK_CYC)) begin
        next_st.thr_run = st.thr_run + 1'b1; // RULE9
      end
    end else begin
      next_st.thr_run = '0;
    end
    // Overcurrent mask then fixed recovery hold
    if (oc_now && st.oc_hold == '0) begin
      next_st.oc_run = st.oc_run + 1'b1;
      if (st.oc_run == bmb_pkg::CNT_W'(bmb_pkg::OC_MASK_CYC)) begin
        next_st.oc_hold = bmb_pkg::CNT_W'(OC_RECOVER_CYC); // RULE17
        next_st.oc_run = '0;
      end
    end else begin
      next_st.oc_run = '0;
    end
    if (st.oc_hold != '0) begin
      next_st.oc_hold = st.oc_hold - 1'b1;
    end
    // Both-low timer toward standby
    if (!a_now && !b_now) begin
      if (st.idle != bmb_pkg::CNT_W'(STANDBY_CYC)) begin
        next_st.idle = st.idle + 1'b1; // RULE3
      end
    end else begin
      next_st.idle = '0;
    end
    case (st.phase)
      BMB_STANDBY: begin
        if (a_now || b_now) begin
          next_st.phase = BMB_WAKE; // RULE7
          next_st.tmr = bmb_pkg::CNT_W'(bmb_pkg::DEAD_CYC);
        end
      end
      BMB_WAKE: begin
        // Short settle, far under the wake bound
        if (st.tmr == '0) begin
          next_st.phase = BMB_RUN; // RULE7
          next_st.blank = bmb_pkg::CNT_W'(bmb_pkg::CHARGE_BLANK_CYC);
        end
      end
      BMB_RUN: begin
        next_st.rev = b_now && !a_now;
        if (st.idle == bmb_pkg::CNT_W'(STANDBY_CYC)) begin
          next_st.phase = BMB_STANDBY; // RULE3
        end else if (a_now != b_now && st.blank == '0 &&
                     st.thr_run ==
                     bmb_pkg::CNT_W'(bmb_pkg::THRESH_BLANK_CYC)) begin
          next_st.phase = BMB_FAST; // RULE15 RULE8
          next_st.tmr = bmb_pkg::CNT_W'(bmb_pkg::FAST_CYC); // RULE11
        end
      end
      BMB_FAST: begin
        if (zero_now) begin
          next_st.phase = BMB_FLOAT; // RULE12
          // Float keeps the off time fixed: slow share is added on
          next_st.tmr = next_st.tmr +
                        bmb_pkg::CNT_W'(bmb_pkg::OFF_TIME_CYC -
                                        bmb_pkg::FAST_CYC); // RULE11
        end else if (st.tmr == '0) begin
          next_st.phase = BMB_SLOW; // RULE11
          next_st.tmr = bmb_pkg::CNT_W'(bmb_pkg::OFF_TIME_CYC -
                                        bmb_pkg::FAST_CYC);
        end
      end
      BMB_SLOW, BMB_FLOAT: begin
        // Float still counts out the fixed off time
        if (st.tmr == '0) begin
          next_st.phase = BMB_RUN; // RULE19
          next_st.blank = bmb_pkg::CNT_W'(bmb_pkg::CHARGE_BLANK_CYC); // RULE8
        end
      end
      default: begin
        next_st.phase = BMB_STANDBY;
      end
    endcase
    // Any input change during decay ends it at once, so PWM recharges
    if ((st.phase == BMB_FAST || st.phase == BMB_SLOW ||
         st.phase == BMB_FLOAT) &&
        (a_now == b_now || a_now != st.a || b_now != st.b)) begin // RULE10
      next_st.phase = BMB_RUN;
    end
    // Leg requests; a phase maps to switch pattern per direction
    {next_st.wa_h, next_st.wa_l, next_st.wb_h, next_st.wb_l} = 4'h0;
    case (next_st.phase)
      BMB_RUN: begin
        if (a_now && b_now) begin
          {next_st.wa_l, next_st.wb_l} = 2'h3; // RULE1
        end else if (a_now) begin
          {next_st.wa_h, next_st.wb_l} = 2'h3; // RULE1 RULE13 RULE19
        end else if (b_now) begin
          {next_st.wb_h, next_st.wa_l} = 2'h3; // RULE1 RULE13
        end
      end
      BMB_FAST: begin
        if (next_st.rev) begin
          {next_st.wa_h, next_st.wb_l} = 2'h3; // RULE13
        end else begin
          {next_st.wb_h, next_st.wa_l} = 2'h3; // RULE13
        end
      end
      BMB_SLOW: begin
        {next_st.wa_l, next_st.wb_l} = 2'h3; // RULE13
      end
      default: begin
        // Standby, wake, float: all off RULE2 RULE20
      end
    endcase
    // Protective off, overrides everything
    if (fault_now || st.oc_hold != '0) begin // RULE17 RULE18
      {next_st.wa_h, next_st.wa_l, next_st.wb_h, next_st.wb_l} = 4'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st <= '0;
      standby <= 1'b1;
    end else begin
      st <= next_st;
      standby <= (next_st.phase == BMB_STANDBY);
    end
  end

  // One leg per output; dead time lives there
  bmb_leg #(.DEAD(bmb_pkg::DEAD_CYC)) u_leg_a (
    .clk(clk),
    .nrst(nrst),
    .want_high(st.wa_h),
    .want_low(st.wa_l),
    .high_on(high_side_a),
    .low_on(low_side_a)
  );
  bmb_leg #(.DEAD(bmb_pkg::DEAD_CYC)) u_leg_b (
    .clk(clk),
    .nrst(nrst),
    .want_high(st.wb_h),
    .want_low(st.wb_l),
    .high_on(high_side_b),
    .low_on(low_side_b)
  );
endmodule // bmb_ctrl
`default_nettype wire

// ===== verilog/bmb_pkg.sv
// Constants of the brushed motor bridge control block.
// Assumes a 250 MHz core clock; times convert to cycles here, except the standby limits.
package bmb_pkg;
  localparam int CLK_PERIOD_PS = 4000;
  // Standby delay, typical and limits, in microseconds
  localparam int STANDBY_TYP_US = 1000;
  localparam int STANDBY_MIN_US = 700;
  localparam int STANDBY_MAX_US = 1500;
  localparam int STANDBY_CYC = STANDBY_TYP_US * 1000000 / CLK_PERIOD_PS;
  // Wake-up bound after standby release, microseconds
  localparam int WAKE_MAX_US = 30;
  localparam int WAKE_CYC = WAKE_MAX_US * 1000000 / CLK_PERIOD_PS;
  // Charge blanking after decay or input change, nanoseconds
  localparam int CHARGE_BLANK_NS = 3600;
  localparam int CHARGE_BLANK_CYC = CHARGE_BLANK_NS * 1000 / CLK_PERIOD_PS;
  // Threshold comparison blanking, nanoseconds
  localparam int THRESH_BLANK_NS = 400;
  localparam int THRESH_BLANK_CYC = THRESH_BLANK_NS * 1000 / CLK_PERIOD_PS;
  // Dead time between leg switches, 200 to 300 ns
  localparam int DEAD_MIN_NS = 200;
  localparam int DEAD_CYC = (DEAD_MIN_NS * 1000 + CLK_PERIOD_PS - 1) /
                            CLK_PERIOD_PS;
  // Fixed off time and its fast-decay share in percent
  localparam int OFF_TIME_NS = 20000;
  localparam int OFF_TIME_CYC = OFF_TIME_NS * 1000 / CLK_PERIOD_PS;
  localparam int FAST_PCT = 50;
  localparam int PCT_FULL = 100;
  localparam int FAST_CYC = OFF_TIME_CYC * FAST_PCT / PCT_FULL;
  // Overcurrent mask in nanoseconds, recovery in microseconds
  localparam int OC_MASK_NS = 1000;
  localparam int OC_MASK_CYC = OC_MASK_NS * 1000 / CLK_PERIOD_PS;
  localparam int OC_RECOVER_US = 1000;
  localparam int OC_RECOVER_CYC = OC_RECOVER_US * 1000000 / CLK_PERIOD_PS;
  localparam int CNT_W = 20;
endpackage

// ===== verilog/bmb_leg.sv
// One half-bridge leg with shoot-through dead time.
// Assumes requested switch states are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module bmb_leg #(
  parameter int DEAD = 50
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic want_high,
  input wire logic want_low,
  output logic high_on,
  output logic low_on
);
  typedef struct packed {
    logic [7:0] dead;
    logic high;
    logic low;
  } bmb_leg_t;
  bmb_leg_t st;
  bmb_leg_t next_st;

  // A switch turns on only after both sat off for the dead time
  always_comb begin
    next_st = st;
    if ((st.high && !want_high) || (st.low && !want_low)) begin
      next_st.high = 1'b0; // RULE14
      next_st.low = 1'b0;
      next_st.dead = 8'(DEAD);
    end else if (st.dead != 8'h00) begin
      next_st.dead = st.dead - 8'h01; // RULE14
    end else if (!st.high && !st.low) begin
      next_st.high = want_high && !want_low;
      next_st.low = want_low && !want_high;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign high_on = st.high;
  assign low_on = st.low;
endmodule // bmb_leg
`default_nettype wire

// ===== dv/bmb_checker.sv
// Checker: leg safety, dead time, decode, standby entry and wake.
// Assumes it is bound into bmb_ctrl and shares its STANDBY_CYC.
`timescale 1ns/1ps
`default_nettype none
module bmb_checker #(
  parameter int STANDBY_CYC = 200
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic direction_input_a,
  input wire logic direction_input_b,
  input wire logic overcurrent_trip,
  input wire logic thermal_trip,
  input wire logic undervoltage_trip,
  input wire logic high_side_a,
  input wire logic high_side_b,
  input wire logic low_side_a,
  input wire logic low_side_b,
  input wire logic standby
);
  logic [19:0] low_cnt;
  logic quiet, off;
  logic [7:0] gap_a, gap_b;
  // Fault-free run and fully floating bridge
  assign quiet = !(overcurrent_trip || thermal_trip || undervoltage_trip);
  assign off = !(high_side_a || high_side_b || low_side_a || low_side_b);
  // Raw both-low run; leads the design count by its sync delay
  always_ff @(posedge clk) begin
    if (!nrst || direction_input_a || direction_input_b) begin
      low_cnt <= 20'h00000;
    end else if (low_cnt != 20'hFFFFF) begin
      low_cnt <= low_cnt + 20'h00001;
    end
  end
  // Cycles each leg has sat fully off, saturating; full after reset
  always_ff @(posedge clk) begin
    if (!nrst) begin
      gap_a <= 8'hFF;
      gap_b <= 8'hFF;
    end else begin
      if (high_side_a || low_side_a) begin
        gap_a <= 8'h00;
      end else if (gap_a != 8'hFF) begin
        gap_a <= gap_a + 8'h01;
      end
      if (high_side_b || low_side_b) begin
        gap_b <= 8'h00;
      end else if (gap_b != 8'hFF) begin
        gap_b <= gap_b + 8'h01;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_no_shoot;
    !(high_side_a && low_side_a) && !(high_side_b && low_side_b);
  endproperty
  a_no_shoot: assert property (p_no_shoot)
    else $error("leg shorted");
  property p_dead_a;
    ($rose(high_side_a) || $rose(low_side_a)) |->
      gap_a >= bmb_pkg::DEAD_CYC;
  endproperty
  a_dead_a: assert property (p_dead_a)
    else $error("leg a dead time short");
  property p_dead_b;
    ($rose(high_side_b) || $rose(low_side_b)) |->
      gap_b >= bmb_pkg::DEAD_CYC;
  endproperty
  a_dead_b: assert property (p_dead_b)
    else $error("leg b dead time short");
  property p_stop;
    (!direction_input_a && !direction_input_b) [*8] |-> ##4 off;
  endproperty
  a_stop: assert property (p_stop)
    else $error("bridge driven in stop");
  property p_brake;
    (quiet && direction_input_a && direction_input_b) [*8] |->
      ##[0:120] (low_side_a && low_side_b);
  endproperty
  a_brake: assert property (p_brake)
    else $error("brake not applied");
  property p_wake;
    (quiet && standby && (direction_input_a || direction_input_b)) [*4]
      |-> ##[0:100] !standby;
  endproperty
  a_wake: assert property (p_wake)
    else $error("no wake from standby");
  property p_sby_min;
    $rose(standby) |-> low_cnt >= STANDBY_CYC;
  endproperty
  a_sby_min: assert property (p_sby_min)
    else $error("standby entered early");
  property p_sby_off;
    standby |-> off;
  endproperty
  a_sby_off: assert property (p_sby_off)
    else $error("switch on in standby");
  property p_fault;
    (thermal_trip || undervoltage_trip) [*8] |-> off;
  endproperty
  a_fault: assert property (p_fault)
    else $error("switch on during trip");
  // Main scenarios reached
  c_sby: cover property ($rose(standby));
  c_fast: cover property (direction_input_a && !direction_input_b &&
                          high_side_b && low_side_a);
  c_brake: cover property (low_side_a && low_side_b);
endmodule // bmb_checker
bind bmb_ctrl bmb_checker #(.STANDBY_CYC(STANDBY_CYC)) i_bmb_checker (
  .clk(clk), .nrst(nrst), .direction_input_a(direction_input_a),
  .direction_input_b(direction_input_b),
  .overcurrent_trip(overcurrent_trip), .thermal_trip(thermal_trip),
  .undervoltage_trip(undervoltage_trip), .high_side_a(high_side_a),
  .high_side_b(high_side_b), .low_side_a(low_side_a),
  .low_side_b(low_side_b), .standby(standby));
`default_nettype wire

// ===== dv/bmb_host.sv
// Host model: drives both direction inputs as levels or direct PWM.
// Assumes the bench calls its tasks; levels move at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module bmb_host #(
  parameter int STANDBY_CYC = 200
) (
  input wire logic clk,
  output logic direction_input_a,
  output logic direction_input_b
);
  // 400 kHz cap as 4 ns cycles per change
  localparam int MIN_HOLD = 313;
  initial begin
    direction_input_a = 1'b0;
    direction_input_b = 1'b0;
  end
  // Driving levels are held at least the rate cap; stop may be shorter
  task automatic drive(input logic a, input logic b, input int hold);
    int n;
    n = ((a || b) && hold < MIN_HOLD) ? MIN_HOLD : hold;
    @(negedge clk);
    direction_input_a = a;
    direction_input_b = b;
    repeat (n) @(negedge clk);
  endtask
  // Stop kept short of the standby window, untouched meanwhile
  task automatic stop_short();
    drive(1'b0, 1'b0, STANDBY_CYC * 7 / 10);
  endtask
  // Held past the longest standby delay, untouched meanwhile
  task automatic rest();
    drive(1'b0, 1'b0, STANDBY_CYC * 3 / 2);
  endtask
endmodule // bmb_host
`default_nettype wire

// ===== dv/tb_brushed_motor_bridge_control.sv
// Bench: decode, standby, chopping, blanking and fault hold.
// Assumes bmb_ctrl at 250 MHz with a shortened standby count.
`timescale 1ns/1ps
`default_nettype none
module tb_brushed_motor_bridge_control;
  localparam int SBY = 200;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic thr = 1'b0;
  logic zc = 1'b0;
  logic oc = 1'b0;
  logic th = 1'b0;
  logic uv = 1'b0;
  logic in_a, in_b, ha, hb, la, lb, sby;
  logic [3:0] sw;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  assign sw = {ha, hb, la, lb};
  always #2 clk = ~clk;
  bmb_host #(.STANDBY_CYC(SBY)) i_bmb_host (.clk(clk),
    .direction_input_a(in_a), .direction_input_b(in_b));
  bmb_ctrl #(.STANDBY_CYC(SBY), .OC_RECOVER_CYC(100)) i_bmb_ctrl (
    .clk(clk), .nrst(nrst), .direction_input_a(in_a),
    .direction_input_b(in_b), .current_threshold_level(thr),
    .zero_current(zc), .overcurrent_trip(oc), .thermal_trip(th),
    .undervoltage_trip(uv), .high_side_a(ha), .high_side_b(hb),
    .low_side_a(la), .low_side_b(lb), .standby(sby));
  task automatic print_verdict();
    if (mismatches == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Standby flag compare
  task automatic chk_sby(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Bounded wait; the compare that follows judges a timeout
  task automatic wait_sw(input logic [3:0] exp);
    int n;
    n = 0;
    while (sw !== exp && n < 3000) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Hang guard, about twice the planned run
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      mismatches++;
      print_verdict();
    end
  end
  task automatic s_decode();
    logic [3:0] exp [3] = '{4'h9, 4'h6, 4'h3};
    chk(sw, 4'h0);
    chk_sby(sby, 1'b1);
    for (int i = 0; i < 3; i++) begin
      i_bmb_host.drive(i != 1, i != 0, 0);
      chk(sw, exp[i]);
      chk_sby(sby, 1'b0);
    end
  endtask
  task automatic s_stop();
    i_bmb_host.stop_short();
    chk(sw, 4'h0);
    chk_sby(sby, 1'b0);
    i_bmb_host.rest();
    chk_sby(sby, 1'b1);
    i_bmb_host.drive(1'b1, 1'b0, 0);
    chk(sw, 4'h9);
  endtask
  // Off time split, blanking and zero-current float
  task automatic s_chop();
    thr = 1'b1;
    wait_sw(4'h6);
    chk(sw, 4'h6);
    thr = 1'b0;
    idle(2300);
    chk(sw, 4'h6);
    idle(300);
    chk(sw, 4'h3);
    idle(2200);
    chk(sw, 4'h3);
    idle(300);
    chk(sw, 4'h9);
    thr = 1'b1;
    idle(600);
    chk(sw, 4'h9);
    wait_sw(4'h6);
    chk(sw, 4'h6);
    zc = 1'b1;
    idle(10);
    chk(sw, 4'h0);
    zc = 1'b0;
    thr = 1'b0;
    idle(4600);
    chk(sw, 4'h0);
    idle(500);
    chk(sw, 4'h9);
    idle(1000);
    thr = 1'b1;
    idle(50);
    thr = 1'b0;
    idle(100);
    chk(sw, 4'h9);
  endtask
  // Direct PWM under a standing threshold never reaches decay
  task automatic s_pwm();
    thr = 1'b1;
    for (int i = 0; i < 4; i++) begin
      i_bmb_host.drive(i[0], !i[0], 600);
      chk(sw, i[0] ? 4'h9 : 4'h6);
    end
    // Reverse chop; a change in slow decay must recharge at once
    i_bmb_host.drive(1'b0, 1'b1, 0);
    wait_sw(4'h9);
    chk(sw, 4'h9);
    thr = 1'b0;
    idle(2600);
    chk(sw, 4'h3);
    i_bmb_host.drive(1'b1, 1'b0, 0);
    chk(sw, 4'h9);
  endtask
  task automatic s_fault();
    for (int k = 0; k < 3; k++) begin
      {oc, th, uv} = 3'h4 >> k;
      idle(k == 0 ? 300 : 20);
      chk(sw, 4'h0);
      {oc, th, uv} = 3'h0;
      idle(300);
      chk(sw, 4'h9);
    end
  endtask
  // Main sequence
  initial begin
    idle(6);
    nrst = 1'b1;
    idle(2);
    s_decode();
    s_stop();
    s_chop();
    s_pwm();
    s_fault();
    print_verdict();
  end
endmodule // tb_brushed_motor_bridge_control
`default_nettype wire
